// *** inc/fsc_pkg.sv ***
// Package: register map, control field positions and state types of the sweep controller
package fsc_pkg;

  // ****************************************
  // Widths
  // ****************************************
  localparam int REG_W  = 30;
  localparam int ADDR_W = 5;
  localparam int HI_W   = 30;
  localparam int LO_W   = 18;
  localparam int WIDE_W = 48;
  localparam int DLY_W  = 21;
  localparam int REG_N  = 32;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [4:0] OFS_GPIO_MASTER = 5'h01;
  localparam logic [4:0] OFS_INT_DIV     = 5'h05;
  localparam logic [4:0] OFS_FRAC_HI     = 5'h06;
  localparam logic [4:0] OFS_FRAC_LO     = 5'h07;
  localparam logic [4:0] OFS_PIN_CFG     = 5'h08;
  localparam logic [4:0] OFS_SEED_HI     = 5'h0A;
  localparam logic [4:0] OFS_SEED_LO     = 5'h0B;
  localparam logic [4:0] OFS_DN_CNT_HI   = 5'h0C;
  localparam logic [4:0] OFS_DN_CNT_LO   = 5'h0D;
  localparam logic [4:0] OFS_SWEEP_CTL   = 5'h0E;
  localparam logic [4:0] OFS_UP_DWELL_HI = 5'h10;
  localparam logic [4:0] OFS_UP_DWELL_LO = 5'h11;
  localparam logic [4:0] OFS_UP_STEP_HI  = 5'h12;
  localparam logic [4:0] OFS_UP_STEP_LO  = 5'h13;
  localparam logic [4:0] OFS_UP_CNT_HI   = 5'h14;
  localparam logic [4:0] OFS_UP_CNT_LO   = 5'h15;

  // ****************************************
  // Field positions and reset values
  // ****************************************
  localparam int CTL_AUTO_A    = 2;
  localparam int CTL_AUTO_B    = 3;
  localparam int CTL_DLY_EN    = 7;
  localparam int CTL_AUTOSEED  = 8;
  localparam int CTL_SWEEP_EN  = 11;
  localparam int CTL_SPI_TRIG  = 12;
  localparam int CTL_PIN_TRIG  = 13;
  localparam int CTL_SYMM      = 22;
  localparam int CTL_SSTEP     = 24;
  localparam int CTL_ONE_WAY   = 25;
  localparam int CTL_DIR_UP    = 26;
  localparam int PIN_CFG_D_DIR = 13;
  localparam int GPIO_MASTER   = 4;
  localparam logic [29:0] REG_RST = 30'h0000_0000;

  typedef enum logic [1:0] {SW_IDLE, SW_WAIT, SW_RAMP, SW_DWELL} fsc_state_t;

endpackage : fsc_pkg

// *** inc/fsc_trig_if.sv ***
// Interface: trigger request and delayed trigger between sweep core and delay unit
`timescale 1ns/100ps
`default_nettype none
interface fsc_trig_if;
  logic                     req;
  logic                     delay_en;
  logic [fsc_pkg::DLY_W-1:0] delay_len;
  logic                     ref_tick;
  logic                     fire;
  logic                     pending;

  modport core  (output req, delay_en, delay_len, ref_tick, input fire, pending);
  modport delay (input req, delay_en, delay_len, ref_tick, output fire, pending);
endinterface : fsc_trig_if
`default_nettype wire

// *** rtl/fsc_trig_delay.sv ***
// Trigger delay unit: holds a trigger for a programmed number of reference periods
`timescale 1ns/100ps
`default_nettype none
module fsc_trig_delay
  import fsc_pkg::*;
(
  input  wire logic clk,
  input  wire logic arst_n,
  fsc_trig_if.delay tif
);

  typedef struct packed {
    logic             pend;
    logic [DLY_W-1:0] cnt;
    logic             fire;
  } fsc_dly_t;

  fsc_dly_t q_ff;
  fsc_dly_t nxt_q;

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    nxt_q      = q_ff;
    nxt_q.fire = 1'b0;
    if (q_ff.pend) begin
      // A delay of zero releases at once rather than waiting for a reference period
      if (tif.delay_len == '0) begin
        nxt_q.pend = 1'b0;
        nxt_q.fire = 1'b1;
      end else if (tif.ref_tick) begin
        if (q_ff.cnt + 21'h00_0001 >= tif.delay_len) begin // R22
          nxt_q.pend = 1'b0;
          nxt_q.fire = 1'b1;
        end else begin
          nxt_q.cnt = q_ff.cnt + 21'h00_0001;
        end
      end
    end else if (tif.req) begin
      if (tif.delay_en) begin // R21
        nxt_q.pend = 1'b1;
        nxt_q.cnt  = '0;
      end else begin
        nxt_q.fire = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      q_ff <= '0;
    end else begin
      q_ff <= nxt_q;
    end
  end

  assign tif.fire    = q_ff.fire;
  assign tif.pending = q_ff.pend;

  // ****************************************
  // Checks
  // ****************************************
  a_nodelay_pass: assert property (@(posedge clk) disable iff (!arst_n) // R21
    (tif.req && !tif.delay_en && !q_ff.pend) |=> tif.fire)
    else $error("undelayed trigger not passed on the next cycle");

  a_delay_wait: assert property (@(posedge clk) disable iff (!arst_n) // R22
    (tif.req && tif.delay_en && !q_ff.pend && tif.delay_len > 21'h00_0001)
      |=> !tif.fire ##0 q_ff.pend)
    else $error("delayed trigger fired too early");

  a_delay_hold: assert property (@(posedge clk) disable iff (!arst_n) // R22
    (q_ff.pend && !tif.ref_tick && tif.delay_len != '0) |=> !tif.fire)
    else $error("delayed trigger fired without a reference period");

endmodule : fsc_trig_delay
`default_nettype wire

// *** rtl/fsc_sweeper.sv ***
// Frequency sweep controller: registers, trigger selection and ramp engine
// Notes on behaviour
// R1: Host loads start divider values first
// R2: Host may load the 48-bit seed
// R3: Sweep enable bit starts sweep operation
// R4: Single-step clear: increments advance automatically
// R5: Single-step set: one increment per trigger
// R6: Bit 25 selects one-way or two-way
// R7: Bits 2,3 select automatic or triggered
// R8: Host uses user sweeps only triggered
// R9: Host uses one-way sweeps only triggered
// R10: Bit 26 sets initial sweep direction
// R11: Bit 22 selects symmetrical or asymmetrical ramps
// R12: Symmetrical ramps reuse up parameters both ways
// R13: Host selects symmetrical mode for one-way
// R14: Up dwell joins 30 upper, 18 lower
// R15: Up step joins 30 upper, 18 lower
// R16: Up count upper 30 bits from register
// R17: Down count joins two registers
// R18: Bit 13 clear takes serial-port triggers
// R19: Bit 13 set takes pin triggers
// R20: Host sets pin input and master enable
// R21: Bit 7 enables trigger delay
// R22: Delay spans programmed reference periods
// R23: Up count lower 18 bits from next register
// R24: Writing bit 12 issues a trigger
// R25: Trigger pin acts on rising edge
// R26: Busy flag spans first to last increment; busy rises at ramp start, before the first automatic increment
// R27: Automatic ramp steps once per reference period
// R28: Triggered two-way ramps alternate direction
`timescale 1ns/100ps
`default_nettype none
module fsc_sweeper
  import fsc_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              arst_n,
  input  wire logic              reg_wr,
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [REG_W-1:0]  reg_wdata,
  input  wire logic [ADDR_W-1:0] rd_addr,
  output logic      [REG_W-1:0]  rd_data,
  input  wire logic              ref_tick,
  input  wire logic              trigger_input_pin,
  output logic                   trigger_pin_armed,
  output logic      [WIDE_W-1:0] frac_value,
  output logic      [WIDE_W-1:0] modulator_seed,
  output logic                   seed_load,
  output logic                   ramp_busy,
  output logic                   sweep_dir_up,
  output logic                   sweep_on
);

  typedef struct packed {
    logic [REG_N-1:0][REG_W-1:0] regs;
    fsc_state_t                  st;
    logic [WIDE_W-1:0]           frac;
    logic [WIDE_W-1:0]           step_cnt;
    logic [WIDE_W-1:0]           dwell_cnt;
    logic                        dir_up;
    logic                        at_end;
    logic                        busy;
    logic                        seed_load;
    logic                        pin_q;
    logic [REG_W-1:0]            rdata;
  } fsc_core_t;

  fsc_core_t q_ff;
  fsc_core_t nxt_q;

  fsc_trig_if tif ();

  // ****************************************
  // Address decode
  // ****************************************
  function automatic logic fsc_is_mapped(input logic [ADDR_W-1:0] a);
    case (a)
      OFS_GPIO_MASTER, OFS_INT_DIV, OFS_FRAC_HI, OFS_FRAC_LO, OFS_PIN_CFG,
      OFS_SEED_HI, OFS_SEED_LO, OFS_DN_CNT_HI, OFS_DN_CNT_LO, OFS_SWEEP_CTL,
      OFS_UP_DWELL_HI, OFS_UP_DWELL_LO, OFS_UP_STEP_HI, OFS_UP_STEP_LO,
      OFS_UP_CNT_HI, OFS_UP_CNT_LO: fsc_is_mapped = 1'b1;
      default:                      fsc_is_mapped = 1'b0;
    endcase
  endfunction : fsc_is_mapped

  // ****************************************
  // Control decode and wide parameters
  // ****************************************
  logic [REG_W-1:0]  ctl;
  logic              sweep_en;
  logic              auto_mode;
  logic              sstep;
  logic              one_way;
  logic              symm;
  logic              ctl_dir_up;
  logic [WIDE_W-1:0] start_frac;
  logic [WIDE_W-1:0] up_dwell;
  logic [WIDE_W-1:0] up_step;
  logic [WIDE_W-1:0] up_count;
  logic [WIDE_W-1:0] dn_count;
  logic [WIDE_W-1:0] cur_count;
  logic [WIDE_W-1:0] frac_plus;
  logic [WIDE_W-1:0] frac_minus;

  assign ctl        = q_ff.regs[OFS_SWEEP_CTL];
  assign sweep_en   = ctl[CTL_SWEEP_EN];                              // R3
  assign auto_mode  = ctl[CTL_AUTO_A] & ctl[CTL_AUTO_B];             // R7
  assign sstep      = ctl[CTL_SSTEP];                                 // R5
  assign one_way    = ctl[CTL_ONE_WAY];                               // R6
  assign symm       = ctl[CTL_SYMM];                                  // R11
  assign ctl_dir_up = ctl[CTL_DIR_UP];                                // R10
  assign start_frac = {q_ff.regs[OFS_FRAC_HI], q_ff.regs[OFS_FRAC_LO][LO_W-1:0]};
  assign up_dwell   = {q_ff.regs[OFS_UP_DWELL_HI], q_ff.regs[OFS_UP_DWELL_LO][LO_W-1:0]}; // R14
  assign up_step    = {q_ff.regs[OFS_UP_STEP_HI], q_ff.regs[OFS_UP_STEP_LO][LO_W-1:0]};   // R15
  assign up_count   = {q_ff.regs[OFS_UP_CNT_HI][HI_W-1:0],                                // R16
                       q_ff.regs[OFS_UP_CNT_LO][LO_W-1:0]};                               // R23
  assign dn_count   = {q_ff.regs[OFS_DN_CNT_HI], q_ff.regs[OFS_DN_CNT_LO][LO_W-1:0]};     // R17
  // Down dwell and step have no register here, so both directions use the up values
  assign cur_count  = (q_ff.dir_up || symm) ? up_count : dn_count;  // R12
  assign frac_plus  = q_ff.frac + up_step;
  assign frac_minus = q_ff.frac - up_step;

  // ****************************************
  // Trigger selection
  // ****************************************
  logic spi_trig;
  logic pin_sel;
  logic pin_ok;
  logic pin_rise;
  logic raw_trig;
  logic trig;

  // The trigger bit is never stored, so it needs no clearing write
  assign spi_trig = reg_wr && (reg_addr == OFS_SWEEP_CTL) && reg_wdata[CTL_SPI_TRIG]
                    && !reg_wdata[CTL_PIN_TRIG];                     // R24
  assign pin_sel  = ctl[CTL_PIN_TRIG];                               // R19
  assign pin_ok   = !q_ff.regs[OFS_PIN_CFG][PIN_CFG_D_DIR]
                    && q_ff.regs[OFS_GPIO_MASTER][GPIO_MASTER];      // R20
  assign pin_rise = trigger_input_pin && !q_ff.pin_q;                // R25
  assign raw_trig = pin_sel ? (pin_rise && pin_ok) : spi_trig;       // R18

  assign tif.req       = raw_trig;
  assign tif.delay_en  = ctl[CTL_DLY_EN];                            // R21
  assign tif.delay_len = q_ff.regs[OFS_INT_DIV][DLY_W-1:0];          // R22
  assign tif.ref_tick  = ref_tick;
  assign trig          = tif.fire;

  fsc_trig_delay u_dly (
    .clk    (clk),
    .arst_n (arst_n),
    .tif    (tif.delay)
  );

  // ****************************************
  // Next state
  // ****************************************
  logic              inc;
  logic              ramp_over;
  logic [WIDE_W-1:0] cnt_base;

  always_comb begin
    nxt_q           = q_ff;
    nxt_q.seed_load = 1'b0;
    nxt_q.pin_q     = trigger_input_pin;
    nxt_q.rdata     = fsc_is_mapped(rd_addr) ? q_ff.regs[rd_addr] : REG_RST;
    inc             = 1'b0;
    ramp_over       = 1'b0;
    cnt_base        = q_ff.step_cnt;

    if (reg_wr && fsc_is_mapped(reg_addr)) begin
      nxt_q.regs[reg_addr] = reg_wdata;
      if (reg_addr == OFS_SWEEP_CTL) begin
        nxt_q.regs[reg_addr][CTL_SPI_TRIG] = 1'b0;
      end
    end

    case (q_ff.st)
      SW_IDLE: begin
        nxt_q.frac   = start_frac;
        nxt_q.busy   = 1'b0;
        nxt_q.at_end = 1'b0;
        nxt_q.dir_up = ctl_dir_up;                                   // R10
        if (sweep_en) begin
          nxt_q.st = SW_WAIT;                                        // R3
        end
      end
      SW_WAIT: begin
        if (auto_mode || trig) begin                                 // R7
          if (one_way && q_ff.at_end) begin
            // One-way ramps hop back to the start and, in triggered mode, wait for the next trigger
            nxt_q.frac   = start_frac;                               // R6
            nxt_q.at_end = 1'b0;
            nxt_q.dir_up = ctl_dir_up;
          end else begin
            nxt_q.st        = SW_RAMP;
            nxt_q.busy      = 1'b1;                                  // R26
            nxt_q.step_cnt  = '0;
            nxt_q.seed_load = ctl[CTL_AUTOSEED];
            cnt_base        = '0;
            inc             = sstep;                                 // R5
          end
        end
      end
      SW_RAMP: begin
        inc = sstep ? trig : ref_tick;                               // R4
      end
      SW_DWELL: begin
        if (ref_tick) begin
          if (q_ff.dwell_cnt + 48'h1 >= up_dwell) begin              // R12
            ramp_over = 1'b1;
          end else begin
            nxt_q.dwell_cnt = q_ff.dwell_cnt + 48'h1;
          end
        end
      end
      default: begin
        nxt_q.st = SW_IDLE;
      end
    endcase

    if (inc) begin
      nxt_q.frac = q_ff.dir_up ? frac_plus : frac_minus;             // R27
      if (cnt_base + 48'h1 >= cur_count) begin
        nxt_q.busy = 1'b0;                                           // R26
        if (sstep) begin
          ramp_over = 1'b1;
        end else begin
          nxt_q.st        = SW_DWELL;
          nxt_q.dwell_cnt = '0;
        end
      end else begin
        nxt_q.step_cnt = cnt_base + 48'h1;
      end
    end

    if (ramp_over) begin
      nxt_q.st = SW_WAIT;
      if (one_way) begin
        nxt_q.at_end = 1'b1;                                         // R6
      end else begin
        nxt_q.dir_up = ~q_ff.dir_up;                                 // R28
      end
    end

    // Clearing the enable abandons any ramp in flight
    if (!sweep_en) begin
      nxt_q.st   = SW_IDLE;
      nxt_q.busy = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      q_ff <= '0;
    end else begin
      q_ff <= nxt_q;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign rd_data           = q_ff.rdata;
  assign trigger_pin_armed = pin_sel && pin_ok;
  assign frac_value        = q_ff.frac;
  assign modulator_seed    = {q_ff.regs[OFS_SEED_HI], q_ff.regs[OFS_SEED_LO][LO_W-1:0]};
  assign seed_load         = q_ff.seed_load;
  assign ramp_busy         = q_ff.busy;
  assign sweep_dir_up      = q_ff.dir_up;
  assign sweep_on          = q_ff.st != SW_IDLE;

  // ****************************************
  // Checks
  // ****************************************
  a_sweep_enable: assert property (@(posedge clk) disable iff (!arst_n) // R3
    (q_ff.st == SW_IDLE && sweep_en) |=> q_ff.st == SW_WAIT || !$past(sweep_en))
    else $error("sweep enable did not leave idle");

  a_auto_step: assert property (@(posedge clk) disable iff (!arst_n) // R27
    (q_ff.st == SW_RAMP && !sstep && ref_tick && sweep_en && q_ff.dir_up)
      |=> q_ff.frac == $past(frac_plus))
    else $error("automatic increment missing in a reference period");

  a_sstep_hold: assert property (@(posedge clk) disable iff (!arst_n) // R5
    (q_ff.st == SW_RAMP && sstep && !trig) |=> q_ff.frac == $past(q_ff.frac))
    else $error("single-step ramp moved without a trigger");

  a_oneway_hop: assert property (@(posedge clk) disable iff (!arst_n) // R6
    (q_ff.st == SW_WAIT && sweep_en && one_way && q_ff.at_end && trig)
      |=> q_ff.frac == $past(start_frac) ##0 q_ff.st == SW_WAIT)
    else $error("one-way end trigger did not hop to start");

  a_auto_start: assert property (@(posedge clk) disable iff (!arst_n) // R7
    (q_ff.st == SW_WAIT && sweep_en && auto_mode && !(one_way && q_ff.at_end))
      |=> q_ff.st != SW_WAIT)
    else $error("automatic mode did not start the ramp");

  a_init_dir: assert property (@(posedge clk) disable iff (!arst_n) // R10
    (q_ff.st == SW_IDLE) |=> q_ff.dir_up == $past(ctl_dir_up))
    else $error("initial direction not taken from control");

  a_dir_flip: assert property (@(posedge clk) disable iff (!arst_n) // R28
    (q_ff.st == SW_DWELL && ref_tick && sweep_en && !one_way
      && q_ff.dwell_cnt + 48'h1 >= up_dwell)
      |=> q_ff.dir_up != $past(q_ff.dir_up) ##0 q_ff.st == SW_WAIT)
    else $error("two-way ramp end did not reverse direction");

  a_spi_trigger: assert property (@(posedge clk) disable iff (!arst_n) // R24
    (spi_trig && !pin_sel && !ctl[CTL_DLY_EN] && !tif.pending) |=> trig)
    else $error("serial-port trigger lost");

  a_pin_edge: assert property (@(posedge clk) disable iff (!arst_n) // R25
    (pin_sel && pin_ok && !tif.pending && !ctl[CTL_DLY_EN])
      |=> trig == ($past(trigger_input_pin) && !$past(q_ff.pin_q)))
    else $error("pin trigger not taken on its rising edge");

  a_busy_ramp: assert property (@(posedge clk) disable iff (!arst_n) // R26
    q_ff.busy == (q_ff.st == SW_RAMP))
    else $error("busy flag out of step with the ramp");

endmodule : fsc_sweeper
`default_nettype wire

// *** testbench/fsc_host_model.sv ***
// Host controller model: register writes and the external trigger pin
`timescale 1ns/100ps
`default_nettype none
module fsc_host_model
  import fsc_pkg::*;
(
  input  wire logic              clk,
  output logic                   reg_wr,
  output logic      [ADDR_W-1:0] reg_addr,
  output logic      [REG_W-1:0]  reg_wdata,
  output logic                   trigger_input_pin
);
  initial begin
    reg_wr            = 1'b0;
    reg_addr          = 5'h00;
    reg_wdata         = 30'h0000_0000;
    trigger_input_pin = 1'b0;
  end

  // ****************************************
  // Register writes
  // ****************************************
  // Address and data are scrambled after the strobe so stale values never look valid
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [REG_W-1:0] d);
    @(negedge clk);
    reg_wr    = 1'b1;
    reg_addr  = a;
    reg_wdata = d;
    @(negedge clk);
    reg_wr    = 1'b0;
    reg_addr  = ~a;
    reg_wdata = ~d;
  endtask : wr

  // Start value, seed and up/down sweep parameters; upper bits of the start, seed and up dwell lower halves are junk
  task automatic load();
    wr(OFS_INT_DIV, 30'h0000_003C);
    wr(OFS_FRAC_HI, 30'h0000_0001);
    wr(OFS_FRAC_LO, 30'h3FFC_0100);
    wr(OFS_SEED_HI, 30'h0000_0005);
    wr(OFS_SEED_LO, 30'h3FFF_FFFF);
    wr(OFS_UP_DWELL_HI, 30'h0000_0000);
    wr(OFS_UP_DWELL_LO, 30'h3FFC_0004);
    wr(OFS_UP_STEP_HI, 30'h0000_0000);
    wr(OFS_UP_STEP_LO, 30'h0000_0003);
    wr(OFS_UP_CNT_HI, 30'h0000_0000);
    wr(OFS_UP_CNT_LO, 30'h0000_0002);
    wr(OFS_DN_CNT_HI, 30'h0000_0000);
    wr(OFS_DN_CNT_LO, 30'h0000_0001);
  endtask : load

  // ****************************************
  // Trigger pin
  // ****************************************
  task automatic arm();
    wr(OFS_PIN_CFG, 30'h0000_0000);
    wr(OFS_GPIO_MASTER, 30'h0000_0010);
  endtask : arm

  task automatic pin_rise();
    @(negedge clk);
    trigger_input_pin = 1'b1;
    repeat (3) @(negedge clk);
    trigger_input_pin = 1'b0;
  endtask : pin_rise
endmodule : fsc_host_model
`default_nettype wire

// *** testbench/fsc_sweeper_tb_top.sv ***
// Testbench top: sweep modes, triggers, delay and register map of the sweep controller
`timescale 1ns/100ps
`default_nettype none
module fsc_sweeper_tb_top
  import fsc_pkg::*;
;
  localparam logic [47:0] START = 48'h0000_0004_0100;
  localparam logic [47:0] SEED  = 48'h0000_0017_FFFF;
  localparam logic [29:0] EN = 30'h1 << CTL_SWEEP_EN, AUTO = 30'h0000_000C,
                          SYM = 30'h1 << CTL_SYMM, UP = 30'h1 << CTL_DIR_UP,
                          SST = 30'h1 << CTL_SSTEP, ONEW = 30'h1 << CTL_ONE_WAY,
                          PIN = 30'h1 << CTL_PIN_TRIG, DLY = 30'h1 << CTL_DLY_EN,
                          SPI = 30'h1 << CTL_SPI_TRIG, ASEED = 30'h1 << CTL_AUTOSEED;

  logic              clk = 1'b0;
  logic              arst_n = 1'b0;
  logic              ref_tick = 1'b0;
  logic [ADDR_W-1:0] rd_addr = 5'h00;
  logic [REG_W-1:0]  rd_data;
  logic              reg_wr;
  logic [ADDR_W-1:0] reg_addr;
  logic [REG_W-1:0]  reg_wdata;
  logic              pin;
  logic              armed;
  logic [WIDE_W-1:0] frac_value;
  logic [WIDE_W-1:0] modulator_seed;
  logic              ramp_busy;
  logic              sweep_dir_up;
  logic              sweep_on;
  logic              seed_ld;
  int                n_seed = 0;
  int                n_mismatch = 0;
  int                tests_run = 0;
  int                tick_div = 0;
  int                n_ticks = 0;
  int                t0;

  always #5 clk = ~clk;

  // Divided reference: one tick every 8 clocks
  always @(negedge clk) begin
    tick_div = (tick_div + 1) % 8;
    ref_tick = (tick_div == 0);
  end
  always @(posedge clk) if (ref_tick) n_ticks++;
  // Read before the edge updates it, so each one-cycle pulse counts once
  always @(posedge clk) if (seed_ld) n_seed++;

  fsc_host_model host (.clk(clk), .reg_wr(reg_wr), .reg_addr(reg_addr),
                       .reg_wdata(reg_wdata), .trigger_input_pin(pin));

  fsc_sweeper dut (.clk(clk), .arst_n(arst_n), .reg_wr(reg_wr), .reg_addr(reg_addr),
                   .reg_wdata(reg_wdata), .rd_addr(rd_addr), .rd_data(rd_data),
                   .ref_tick(ref_tick), .trigger_input_pin(pin),
                   .trigger_pin_armed(armed), .frac_value(frac_value),
                   .modulator_seed(modulator_seed), .seed_load(seed_ld),
                   .ramp_busy(ramp_busy), .sweep_dir_up(sweep_dir_up),
                   .sweep_on(sweep_on));

  // ****************************************
  // Checking tasks
  // ****************************************
  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic rd(input logic [ADDR_W-1:0] a, input logic [REG_W-1:0] exp);
    @(negedge clk);
    rd_addr = a;
    @(negedge clk);
    chk({18'h0, rd_data}, {18'h0, exp});
  endtask : rd

  task automatic wait_busy(input logic lvl);
    for (int i = 0; i < 400 && ramp_busy !== lvl; i++) @(negedge clk);
    chk({47'h0, ramp_busy}, {47'h0, lvl});
  endtask : wait_busy

  task automatic print_verdict();
    $display("Comparisons: %0d, mismatches: %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : print_verdict

  // ****************************************
  // Test sequence
  // ****************************************
  initial begin
    repeat (8) @(negedge clk);
    arst_n = 1'b1;
    rd(OFS_UP_CNT_HI, REG_RST);
    host.load();
    host.wr(5'h09, 30'h3FFF_FFFF);
    rd(5'h09, 30'h0000_0000);
    rd(OFS_UP_CNT_LO, 30'h0000_0002);
    chk(frac_value, START);
    chk(modulator_seed, SEED);
    // Automatic two-way, asymmetric then symmetric
    for (int s = 0; s < 2; s++) begin
      host.wr(OFS_SWEEP_CTL, EN | AUTO | UP | (s == 1 ? SYM : 30'h0));
      wait_busy(1'b1);
      chk({47'h0, sweep_dir_up}, 48'h1);
      wait_busy(1'b0);
      chk(frac_value, START + 48'd6);
      t0 = n_ticks;
      wait_busy(1'b1);
      chk(48'(n_ticks - t0), 48'd4);
      chk({47'h0, sweep_dir_up}, 48'h0);
      wait_busy(1'b0);
      chk(frac_value, START + 48'd6 - (s == 1 ? 48'd6 : 48'd3));
      host.wr(OFS_SWEEP_CTL, 30'h0000_0000);
      @(negedge clk);
      chk({47'h0, sweep_on}, 48'h0);
      // Idle reloads the start value one edge after it is entered
      @(negedge clk);
      chk(frac_value, START);
    end
    // Single-step: one increment per trigger only
    host.wr(OFS_SWEEP_CTL, EN | SST | SYM | UP);
    repeat (20) @(negedge clk);
    chk(frac_value, START);
    host.wr(OFS_SWEEP_CTL, EN | SST | SYM | UP | SPI);
    repeat (20) @(negedge clk);
    chk(frac_value, START + 48'd3);
    chk({47'h0, ramp_busy}, 48'h1);
    rd(OFS_SWEEP_CTL, EN | SST | SYM | UP);
    host.wr(OFS_SWEEP_CTL, EN | SST | SYM | UP | SPI);
    repeat (4) @(negedge clk);
    chk(frac_value, START + 48'd6);
    chk({47'h0, ramp_busy}, 48'h0);
    host.wr(OFS_SWEEP_CTL, 30'h0000_0000);
    // Pin trigger: serial trigger refused, rising edge accepted
    host.arm();
    host.wr(OFS_SWEEP_CTL, EN | PIN | SYM | UP);
    chk({47'h0, armed}, 48'h1);
    host.wr(OFS_SWEEP_CTL, EN | PIN | SYM | UP | SPI);
    repeat (20) @(negedge clk);
    chk({47'h0, ramp_busy}, 48'h0);
    chk(frac_value, START);
    host.pin_rise();
    wait_busy(1'b1);
    wait_busy(1'b0);
    chk(frac_value, START + 48'd6);
    host.wr(OFS_SWEEP_CTL, 30'h0000_0000);
    // Delayed serial trigger: three reference periods
    host.wr(OFS_INT_DIV, 30'h0000_0003);
    host.wr(OFS_SWEEP_CTL, EN | DLY | SYM | UP | ASEED);
    @(posedge clk iff ref_tick === 1'b1);
    host.wr(OFS_SWEEP_CTL, EN | DLY | SYM | UP | ASEED | SPI);
    t0 = n_ticks;
    wait_busy(1'b1);
    chk(48'(n_ticks - t0), 48'd3);
    host.wr(OFS_SWEEP_CTL, 30'h0000_0000);
    chk(48'(n_seed), 48'h1);
    // Triggered one-way, starting downward: ramp, hop back, restart
    host.wr(OFS_SWEEP_CTL, EN | ONEW | SYM);
    host.wr(OFS_SWEEP_CTL, EN | ONEW | SYM | SPI);
    wait_busy(1'b1);
    chk({47'h0, sweep_dir_up}, 48'h0);
    wait_busy(1'b0);
    chk(frac_value, START - 48'd6);
    repeat (60) @(negedge clk);
    host.wr(OFS_SWEEP_CTL, EN | ONEW | SYM | SPI);
    repeat (4) @(negedge clk);
    chk(frac_value, START);
    chk({47'h0, ramp_busy}, 48'h0);
    host.wr(OFS_SWEEP_CTL, EN | ONEW | SYM | SPI);
    wait_busy(1'b1);
    host.wr(OFS_SWEEP_CTL, 30'h0000_0000);
    print_verdict();
  end

  // Watchdog: the sequence needs well under 5000 clocks
  initial begin
    #200000;
    n_mismatch++;
    print_verdict();
  end
endmodule : fsc_sweeper_tb_top
`default_nettype wire
